/* hdl/tmoc_regs.vh */
// register map, field positions, reset values, output action codes and count limit of the timer output/trigger block
`ifndef TMOC_REGS_VH
`define TMOC_REGS_VH

// byte addresses on the apb bus
`define TMOC_ADDR_STATUS_OUT   8'h00
`define TMOC_ADDR_TRIG_CTRL    8'h04
`define TMOC_ADDR_MAIN_CTRL    8'h08
`define TMOC_ADDR_CMP_A        8'h0c
`define TMOC_ADDR_CMP_B        8'h10
`define TMOC_ADDR_COUNT        8'h14
`define TMOC_ADDR_IRQ_STATUS   8'h18
`define TMOC_ADDR_IRQ_MASK     8'h1c

// timer_status_output_select fields
`define TMOC_ST_MATCH_B_FLAG   7
`define TMOC_ST_MATCH_A_FLAG   6
`define TMOC_ST_OVERFLOW_FLAG  5
`define TMOC_ST_RSVD           4
`define TMOC_ST_OUT_B_HI       3
`define TMOC_ST_OUT_B_LO       2
`define TMOC_ST_OUT_A_HI       1
`define TMOC_ST_OUT_A_LO       0

// timer_trigger_control fields
`define TMOC_TC_RSVD_HI        7
`define TMOC_TC_RSVD_LO        5
`define TMOC_TC_EDGE_HI        4
`define TMOC_TC_EDGE_LO        3
`define TMOC_TC_GATE_EN        2
`define TMOC_TC_RSVD_B1        1
`define TMOC_TC_EXTRA_CLK      0

// timer_main_control fields
`define TMOC_MC_CLEAR_HI       4
`define TMOC_MC_CLEAR_LO       3
`define TMOC_MC_CLK_HI         2
`define TMOC_MC_CLK_LO         0

// interrupt status / mask bit positions
`define TMOC_IRQ_OVERFLOW      0
`define TMOC_IRQ_MATCH_A       1
`define TMOC_IRQ_MATCH_B       2

// reset values
`define TMOC_RST_OUT_SEL       4'h0
`define TMOC_RST_EDGE_SEL      2'h0
`define TMOC_RST_MAIN_CTRL     5'h00
`define TMOC_RST_CLEAR_SEL     2'h0
`define TMOC_RST_CLK_SEL       3'h0
`define TMOC_RST_CMP           8'hff
`define TMOC_RST_COUNT         8'h00
`define TMOC_RST_IRQ_MASK      3'h0

// output action codes
`define TMOC_ACT_NONE          2'h0
`define TMOC_ACT_ZERO          2'h1
`define TMOC_ACT_ONE           2'h2
`define TMOC_ACT_TOGGLE        2'h3

// count limits
`define TMOC_COUNT_MAX         8'hff

`endif

/* hdl/tmoc_top.v */
// timer status flags, compare-match output select and trigger control with apb register access
// Contract
// - match A flag clears only by a write of 0 after reading it as 1
// - overflow flag sets when the 8-bit count wraps from ff to 00
// - overflow flag resets to 0 and clears only by read-1-then-write-0
// - reserved bits 4 of status and 7:5, 1 of trigger control read 1
// - bits 3:2 pick pin action on match B: hold, 0, 1, toggle
// - bits 1:0 pick pin action on match A: hold, 0, 1, toggle
// - match A and match B actions are independent, each on its own event
// - output pin is 0 after reset until the first compare match
// - trigger edge field bits 4:3: off, rising, falling, both edges
// - gate enable 1: a counter clear halts counting until selected trigger edge
// - gate enable 0 (reset): trigger ignored, counter runs on after clear
// - bit 0 extra clock select combines with clock select to choose source
// - match flags B and A set when count equals compare B or A
// - internal clocks 001: /4 or /8, 010: /16 or /32, 011: /64 or /128
// - clear select: 00 none, 01 match A, 10 match B, 11 reset pin rising
`timescale 1ns/1ps
`include "tmoc_regs.vh"
`default_nettype none

module tmoc_top (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // pins
    input  wire        trigger_pin,
    input  wire        ext_clock_pin,
    input  wire        counter_reset_input_pin,
    output reg         timer_output_pin,
    // interrupt
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    reg  [7:0] timer_count;
    reg  [7:0] compare_a_value;
    reg  [7:0] compare_b_value;
    reg        match_a_flag;
    reg        match_b_flag;
    reg        overflow_flag;
    reg        armed_a;
    reg        armed_b;
    reg        armed_ovf;
    reg  [3:0] out_sel;
    reg  [1:0] trigger_edge_sel;
    reg        trigger_gate_enable;
    reg        extra_clock_select;
    reg  [1:0] clear_select;
    reg  [2:0] clock_select;
    reg        halted;
    reg  [2:0] irq_status;
    reg  [2:0] irq_mask;
    reg  [6:0] prescale;
    reg  [2:0] sync1;
    reg  [2:0] sync2;
    reg  [2:0] sync_prev;
    reg        int_clk_prev;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; the slave never waits
    wire       wr_acc  = psel & penable & pwrite;
    wire       rd_acc  = psel & penable & ~pwrite;
    wire       mapped  = (paddr[1:0] == 2'h0) && (paddr[7:2] <= 6'h07);
    wire       wr_stat = wr_acc && (paddr == `TMOC_ADDR_STATUS_OUT);
    wire       rd_stat = rd_acc && (paddr == `TMOC_ADDR_STATUS_OUT);
    wire       wr_trig = wr_acc && (paddr == `TMOC_ADDR_TRIG_CTRL);
    wire       wr_main = wr_acc && (paddr == `TMOC_ADDR_MAIN_CTRL);
    wire       wr_cmpa = wr_acc && (paddr == `TMOC_ADDR_CMP_A);
    wire       wr_cmpb = wr_acc && (paddr == `TMOC_ADDR_CMP_B);
    wire       wr_irqs = wr_acc && (paddr == `TMOC_ADDR_IRQ_STATUS);
    wire       wr_irqm = wr_acc && (paddr == `TMOC_ADDR_IRQ_MASK);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: bit 0 trigger, bit 1 external clock, bit 2 reset pin
    wire [2:0] pins_raw = {counter_reset_input_pin, ext_clock_pin, trigger_pin};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1     <= 3'h0;
            sync2     <= 3'h0;
            sync_prev <= 3'h0;
        end else begin
            sync1     <= pins_raw;
            sync2     <= sync1;
            sync_prev <= sync2;
        end
    end

    wire [2:0] rise = sync2 & ~sync_prev;
    wire [2:0] fall = ~sync2 & sync_prev;

    ////////////////////////////////////////////////////////////////////////
    // count source selection; internal ticks come from falling edges of a divider bit
    reg        int_clk;
    reg        count_tick;

    always @* begin
        int_clk = 1'b0;
        case ({clock_select[1:0], extra_clock_select})
            3'b010:  int_clk = prescale[1];   // sys_clk / 4
            3'b011:  int_clk = prescale[2];   // sys_clk / 8
            3'b100:  int_clk = prescale[3];   // sys_clk / 16
            3'b101:  int_clk = prescale[4];   // sys_clk / 32
            3'b110:  int_clk = prescale[5];   // sys_clk / 64
            3'b111:  int_clk = prescale[6];   // sys_clk / 128
            default: int_clk = 1'b0;
        endcase
    end

    always @* begin
        count_tick = 1'b0;
        case (clock_select)
            3'h1, 3'h2, 3'h3: count_tick = int_clk_prev & ~int_clk;
            3'h5:    count_tick = rise[1];
            3'h6:    count_tick = fall[1];
            3'h7:    count_tick = rise[1] | fall[1];
            default: count_tick = 1'b0;   // clock input prohibited
        endcase
    end

    // a source switch may look like a falling edge and add one count, as on the real part
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale     <= 7'h00;
            int_clk_prev <= 1'b0;
        end else begin
            prescale     <= prescale + 7'h01;
            int_clk_prev <= int_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare, overflow and clear events
    wire       tick      = count_tick & ~halted;
    wire       match_a   = tick && (timer_count == compare_a_value);
    wire       match_b   = tick && (timer_count == compare_b_value);
    wire       overflow  = tick && (timer_count == `TMOC_COUNT_MAX);
    reg        clear_evt;

    always @* begin
        clear_evt = 1'b0;
        case (clear_select)
            2'h1:    clear_evt = match_a;
            2'h2:    clear_evt = match_b;
            2'h3:    clear_evt = rise[2];
            default: clear_evt = 1'b0;
        endcase
    end

    wire       trig_edge = (trigger_edge_sel[0] & rise[0]) | (trigger_edge_sel[1] & fall[0]);

    // counter and halt-on-clear gating
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_count <= `TMOC_RST_COUNT;
            halted      <= 1'b0;
        end else begin
            if (clear_evt)
                timer_count <= `TMOC_RST_COUNT;
            else if (tick)
                timer_count <= timer_count + 8'h01; // wraps ff to 00
            if (!trigger_gate_enable)
                halted <= 1'b0;
            else if (trig_edge)
                halted <= 1'b0; // restart wins over a clear in the same cycle
            else if (clear_evt)
                halted <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pin; simultaneous matches resolve toggle over 1 over 0
    wire [1:0] act_a = match_a ? out_sel[1:0] : `TMOC_ACT_NONE;
    wire [1:0] act_b = match_b ? out_sel[3:2] : `TMOC_ACT_NONE;
    reg        next_out;

    always @* begin
        if (act_a == `TMOC_ACT_TOGGLE || act_b == `TMOC_ACT_TOGGLE)
            next_out = ~timer_output_pin;
        else if (act_a == `TMOC_ACT_ONE || act_b == `TMOC_ACT_ONE)
            next_out = 1'b1;
        else if (act_a == `TMOC_ACT_ZERO || act_b == `TMOC_ACT_ZERO)
            next_out = 1'b0;
        else
            next_out = timer_output_pin;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            timer_output_pin <= 1'b0;
        else
            timer_output_pin <= next_out;
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags: a read that sees 1 arms the clear, the next status write of 0 clears
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_a_flag  <= 1'b0;
            match_b_flag  <= 1'b0;
            overflow_flag <= 1'b0;
            armed_a       <= 1'b0;
            armed_b       <= 1'b0;
            armed_ovf     <= 1'b0;
        end else begin
            // setting beats a clearing write in the same cycle; writing 1 never sets
            if (match_a)
                match_a_flag <= 1'b1;
            else if (wr_stat && armed_a && !pwdata[`TMOC_ST_MATCH_A_FLAG])
                match_a_flag <= 1'b0;
            if (match_b)
                match_b_flag <= 1'b1;
            else if (wr_stat && armed_b && !pwdata[`TMOC_ST_MATCH_B_FLAG])
                match_b_flag <= 1'b0;
            if (overflow)
                overflow_flag <= 1'b1;
            else if (wr_stat && armed_ovf && !pwdata[`TMOC_ST_OVERFLOW_FLAG])
                overflow_flag <= 1'b0;
            // any status write consumes the arming
            if (rd_stat) begin
                armed_a   <= match_a_flag;
                armed_b   <= match_b_flag;
                armed_ovf <= overflow_flag;
            end else if (wr_stat) begin
                armed_a   <= 1'b0;
                armed_b   <= 1'b0;
                armed_ovf <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_sel             <= `TMOC_RST_OUT_SEL;
            trigger_edge_sel    <= `TMOC_RST_EDGE_SEL;
            trigger_gate_enable <= 1'b0;
            extra_clock_select  <= 1'b0;
            clear_select        <= `TMOC_RST_CLEAR_SEL;
            clock_select        <= `TMOC_RST_CLK_SEL;
            compare_a_value     <= `TMOC_RST_CMP;
            compare_b_value     <= `TMOC_RST_CMP;
            irq_mask            <= `TMOC_RST_IRQ_MASK;
        end else begin
            if (wr_stat)
                out_sel <= pwdata[`TMOC_ST_OUT_B_HI:`TMOC_ST_OUT_A_LO];
            if (wr_trig) begin
                trigger_edge_sel    <= pwdata[`TMOC_TC_EDGE_HI:`TMOC_TC_EDGE_LO];
                trigger_gate_enable <= pwdata[`TMOC_TC_GATE_EN];
                extra_clock_select  <= pwdata[`TMOC_TC_EXTRA_CLK];
            end
            if (wr_main) begin
                clear_select <= pwdata[`TMOC_MC_CLEAR_HI:`TMOC_MC_CLEAR_LO];
                clock_select <= pwdata[`TMOC_MC_CLK_HI:`TMOC_MC_CLK_LO];
            end
            if (wr_cmpa)
                compare_a_value <= pwdata[7:0];
            if (wr_cmpb)
                compare_b_value <= pwdata[7:0];
            if (wr_irqm)
                irq_mask <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, write one to clear, a new event wins
    wire [2:0] irq_events = {match_b, match_a, overflow};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            irq_status <= 3'h0;
        else if (wr_irqs)
            irq_status <= (irq_status & ~pwdata[2:0]) | irq_events;
        else
            irq_status <= irq_status | irq_events;
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup phase so it stands through the access
    reg [7:0] rd_mux;

    always @* begin
        case (paddr)
            `TMOC_ADDR_STATUS_OUT: rd_mux = {match_b_flag, match_a_flag, overflow_flag, 1'b1, out_sel};
            `TMOC_ADDR_TRIG_CTRL:  rd_mux = {3'h7, trigger_edge_sel, trigger_gate_enable, 1'b1,
                                             extra_clock_select};
            `TMOC_ADDR_MAIN_CTRL:  rd_mux = {3'h0, clear_select, clock_select};
            `TMOC_ADDR_CMP_A:      rd_mux = compare_a_value;
            `TMOC_ADDR_CMP_B:      rd_mux = compare_b_value;
            `TMOC_ADDR_COUNT:      rd_mux = timer_count;
            `TMOC_ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_status};
            `TMOC_ADDR_IRQ_MASK:   rd_mux = {5'h00, irq_mask};
            default:               rd_mux = 8'h00;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= {24'h000000, rd_mux};
    end

endmodule // tmoc_top

`default_nettype wire

/* bench/tmoc_far.sv */
// far-side model: trigger source, count clock and clear pin pulses, output load
`timescale 1ns/1ps
`default_nettype none
module tmoc_far (
    // clock
    input  wire logic sys_clk,
    // pins
    input  wire logic timer_output_pin,
    output var logic  trigger_pin,
    output var logic  ext_clock_pin,
    output var logic  counter_reset_input_pin
);
    // all three pins start low; set_trig moves the trigger, pulse moves the count clock and clear pins
    initial begin
        trigger_pin = 1'b0;
        ext_clock_pin = 1'b0;
        counter_reset_input_pin = 1'b0;
    end
    // load side: counts every level change of the output pin
    int   out_changes = 0;
    logic out_seen    = 1'b0;
    always @(posedge sys_clk) begin
        out_seen <= timer_output_pin;
        if (timer_output_pin !== out_seen)
            out_changes <= out_changes + 1;
    end
    // edges launched just after a rising edge; the pin is level, no pull
    task set_trig(input logic v);
        @(posedge sys_clk);
        trigger_pin <= v;
    endtask
    // k clean pulses on the clear pin (sel 1) or the count clock pin (sel 0);
    // four cycles high and four low between pulses so the synchroniser sees both edges
    task pulse(input logic sel, input int k);
        repeat (k) begin
            @(posedge sys_clk);
            if (sel)
                counter_reset_input_pin <= 1'b1;
            else
                ext_clock_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            counter_reset_input_pin <= 1'b0;
            ext_clock_pin <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
    endtask
endmodule // tmoc_far
`default_nettype wire

/* bench/tmoc_chk.sv */
// port-level checker for the timer output/trigger block
`timescale 1ns/1ps
`default_nettype none
module tmoc_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // pins
    input wire logic        trigger_pin,
    input wire logic        ext_clock_pin,
    input wire logic        counter_reset_input_pin,
    input wire logic        timer_output_pin,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // phase decode
    wire rd_setup = psel & ~penable & ~pwrite;
    wire acc      = psel & penable;
    ////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && paddr > 8'h1c |-> pslverr) else $error("no error");
    a_err_mapped: assert property (acc && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("false error");
    a_unmap_zero: assert property (rd_setup && paddr > 8'h1c |=> prdata == 32'h0) else $error("bad data");
    a_status_rsvd: assert property (rd_setup && paddr == 8'h00 |=> prdata[4] && prdata[31:8] == 24'h0)
        else $error("status reserved bit");
    a_trig_rsvd: assert property (rd_setup && paddr == 8'h04 |=> prdata[7:5] == 3'h7 && prdata[1])
        else $error("trigger reserved bits");
    a_out_after_rst: assert property ($rose(rst_n) |-> !timer_output_pin) else $error("output high");
    a_mask_irq_off: assert property (acc && pwrite && paddr == 8'h1c && pwdata[2:0] == 3'h0 |=> !irq)
        else $error("irq while masked");
    a_rdata_stands: assert property (!rd_setup |=> $stable(prdata)) else $error("read data moved");
    ////////////////////////////////////////////////////////////////////////
    c_status_read: cover property (rd_setup && paddr == 8'h00);
    c_irq_rise: cover property ($rose(irq));
    c_out_rise: cover property ($rose(timer_output_pin));
endmodule // tmoc_chk
bind tmoc_top tmoc_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .trigger_pin(trigger_pin), .ext_clock_pin(ext_clock_pin),
    .counter_reset_input_pin(counter_reset_input_pin), .timer_output_pin(timer_output_pin), .irq(irq));
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the timer output/trigger block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
    logic        sys_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire         pready;
    wire         pslverr;
    wire  [31:0] prdata;
    wire         trig;
    wire         ext_clk;
    wire         rst_pin;
    wire         tout;
    wire         irq;
    logic [31:0] q;
    logic [31:0] m;
    logic        err;
    int          miscompares = 0;
    int          checks = 0;
    int          n;
    int          x;
    tmoc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .trigger_pin(trig), .ext_clock_pin(ext_clk), .counter_reset_input_pin(rst_pin),
        .timer_output_pin(tout), .irq(irq));
    tmoc_far far (.sys_clk(sys_clk), .timer_output_pin(tout), .trigger_pin(trig),
        .ext_clock_pin(ext_clk), .counter_reset_input_pin(rst_pin));
    ////////////////////////////////////////////////////////////////////////
    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // one apb transfer; a spare edge at the end lets register-driven outputs settle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // counts edges until the output pin shows v
    task wait_pin(input logic v);
        n = 0;
        while (tout !== v && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (tout !== v) begin
            miscompares++;
            $display("[FAIL] %0t output pin wait ran out", $time);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(8'h00, 32'h10);
        rd(8'h04, 32'he2);
        `CHK(tout, 1'b0)
        rd(8'h20, 32'h0);
        `CHK(err, 1'b1)
    endtask
    // compare values stay ff so both matches coincide with the wrap
    task t_flags;
        wr(8'h08, 32'h01);
        cyc(1150);
        wr(8'h08, 32'h00);
        wr(8'h00, 32'h00);
        rd(8'h00, 32'hf0);
        `CHK(tout, 1'b0)
        wr(8'h00, 32'h80);
        rd(8'h00, 32'h90);
        wr(8'h00, 32'h00);
        rd(8'h00, 32'h10);
        wr(8'h1c, 32'h7);
        `CHK(irq, 1'b1)
        wr(8'h1c, 32'h0);
        `CHK(irq, 1'b0)
        wr(8'h1c, 32'h7);
        wr(8'h18, 32'h7);
        rd(8'h18, 32'h0);
        `CHK(irq, 1'b0)
    endtask
    // match a at 10, match b at 20 and clears, so one period is 33 ticks
    task t_output;
        wr(8'h0c, 32'h10);
        wr(8'h10, 32'h20);
        wr(8'h00, 32'h06);
        wr(8'h08, 32'h11);
        wait_pin(1'b1);
        wait_pin(1'b0);
        `CHK(n, 64)
        for (x = 0; x < 2; x++) begin
            wr(8'h04, x);
            wr(8'h00, 32'h03);
            wait_pin(~tout);
            wait_pin(~tout);
            `CHK(n, 132 << x)
        end
    endtask
    // falling edge selected: a rising trigger must not restart the halted count
    task t_trigger;
        wr(8'h04, 32'h14);
        rd(8'h04, 32'hf6);
        cyc(300);
        rd(8'h14, 32'h0);
        far.set_trig(1'b1);
        cyc(20);
        rd(8'h14, 32'h0);
        far.set_trig(1'b0);
        cyc(40);
        apb(1'b0, 8'h14, 32'h0);
        `CHK(q != 32'h0, 1'b1)
        for (x = 0; x < 4; x++) begin
            wr(8'h04, x << 3);
            rd(8'h04, 32'he2 | (x << 3));
        end
        cyc(300);
        apb(1'b0, 8'h14, 32'h0);
        m = q;
        cyc(20);
        apb(1'b0, 8'h14, 32'h0);
        `CHK(q != m, 1'b1)
    endtask
    // external count edges, the clear pin, clear on match A, gated restart on a rising trigger, mid-run reset
    task t_pins;
        for (x = 5; x < 8; x++) begin
            wr(8'h08, x);
            apb(1'b0, 8'h14, 32'h0);
            m = q;
            far.pulse(1'b0, 3);
            rd(8'h14, (m + ((x == 7) ? 6 : 3)) & 32'hff);
        end
        wr(8'h08, 32'h1d);
        far.pulse(1'b1, 1);
        rd(8'h14, 32'h0);
        far.pulse(1'b0, 2);
        rd(8'h14, 32'h2);
        wr(8'h0c, 32'h3);
        wr(8'h08, 32'h0d);
        m = far.out_changes;
        far.pulse(1'b0, 2);
        rd(8'h14, 32'h0);
        `CHK(far.out_changes, m + 1)
        wr(8'h08, 32'h1d);
        wr(8'h04, 32'h0c);
        far.pulse(1'b1, 1);
        far.pulse(1'b0, 2);
        rd(8'h14, 32'h0);
        far.set_trig(1'b1);
        cyc(4);
        far.pulse(1'b0, 2);
        rd(8'h14, 32'h2);
        far.set_trig(1'b0);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        `CHK(tout, 1'b0)
        rd(8'h00, 32'h10);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_flags();
        t_output();
        t_trigger();
        t_pins();
        wrap_up();
    end
    // hang guard, well beyond the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        wrap_up();
    end
endmodule // tb
`default_nettype wire
